// [rtl/rev_resp_pkg.sv]
package rev_resp_pkg;
	// error report bit positions
	localparam int ERR_SOT       = 0;
	localparam int ERR_SOT_SYNC  = 1;
	localparam int ERR_EOT_SYNC  = 2;
	localparam int ERR_LP_SYNC   = 4;
	localparam int ERR_ECC_SINGLE = 8;
	localparam int ERR_ECC_MULTI = 9;
	localparam int ERR_CHECKSUM  = 10;
	localparam int ERR_CMD_UNREC = 11;
	localparam int ERR_VCID      = 12;
	localparam int ERR_PROTOCOL  = 15;
	localparam logic [15:0] ERR_RESET = 16'h0000;
	localparam logic [15:0] ERR_ABORT_MASK = 16'h9A03;
	localparam logic [15:0] ERR_NODATA_MASK = 16'h0614;
	// reverse data types and trigger codes
	localparam logic [5:0] DT_ACK_ERR    = 6'h02;
	localparam logic [5:0] DT_READ_SHORT = 6'h21;
	localparam logic [7:0] ACK_TRIGGER   = 8'h21;
	localparam logic [7:0] TE_TRIGGER    = 8'h5D;
	localparam logic [1:0] LANE_REVERSE  = 2'h0;
	// AXI register offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ERR    = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_RDATA  = 8'h0C;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one received-transmission summary from the forward path
	typedef struct packed {
		logic        is_read;
		logic        ecc_single;
		logic        ecc_multi;
		logic [15:0] other_err;
	} rx_summary_t;

	// one reverse byte toward the physical layer
	typedef struct packed {
		logic       valid;
		logic       trigger;
		logic       last;
		logic [7:0] data;
	} tx_byte_t;
endpackage : rev_resp_pkg

// [rtl/rev_resp.sv]
// What this block does
// RL1: reverse traffic leaves on lane zero only; other lanes stay forward-only.
// RL2: reverse traffic uses low power signalling only, never high speed.
// RL3: every reverse packet carries header ECC; no checksum so long footers are zero.
// RL4: every reverse transmission ends with a bus turnaround back to the host.
// RL5: a tearing effect trigger byte can be requested and sent.
// RL6: acknowledge trigger only when no error stored since the last reverse traffic.
// RL7: sending an error report clears all stored error flags.
// RL8: single-bit header error is corrected, packet used, flag set and reported.
// RL9: multi-bit header error drops the transmission, sets flag and reports it.
// RL10: the ECC byte sent is computed over the header actually sent.
// RL11: video mode corrects single-bit and drops on multi-bit; reporting optional.
// RL12: host checks ECC and checksum, each separately switchable.
// RL13: checksum bytes go only with long packets.
// RL14: respond only after a turnaround, then hand the bus back.
// RL15: clean non-read command answered with the acknowledge trigger.
// RL16: clean read request answered with the read data.
// RL17: read with only single-bit error sends data then a 4-byte report.
// RL18: non-read with only single-bit error executes, then sends a 4-byte report.
// RL19: read with multi-bit error sends only the report, no data.
// RL20: non-read with multi-bit error is not executed; report is sent.
// RL21: link, channel, protocol or command errors: report only, no access.
// RL22: sync or checksum errors send a report; reads get no data.
// RL23: report is identifier, flags 7..0, flags 15..8, then header ECC.
// RL24: flag 8 marks corrected single-bit, flag 9 uncorrected multi-bit.
// RL25: acknowledge is the trigger byte 00100001 first to last.
// RL26: error flags are sticky until the next report clears them.
`timescale 1ns/10ps
`default_nettype none
module rev_resp
	import rev_resp_pkg::*;
#(
	parameter logic [1:0] VIRTUAL_CHANNEL_ID = 2'h0
) (
	// clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_SYS_RST,
	// forward path results, one pulse per transmission
	input  wire logic        I_RX_DONE,
	input  wire rx_summary_t I_RX_SUM,
	input  wire logic        I_TURNAROUND,
	input  wire logic        I_TE_REQ,
	// read data source
	input  wire logic [15:0] I_RD_DATA,
	// reverse byte stream to the physical layer
	input  wire logic        I_TX_READY,
	output tx_byte_t         O_TX,
	output logic [1:0]       O_TX_LANE,
	output logic             O_TX_LOW_POWER,
	output logic             O_BUS_RETURN,
	output logic             O_EXEC,
	// AXI4-Lite slave
	input  wire logic        S_AXI_AWVALID,
	input  wire logic [7:0]  S_AXI_AWADDR,
	output logic             S_AXI_AWREADY,
	input  wire logic        S_AXI_WVALID,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	output logic             S_AXI_WREADY,
	output logic             S_AXI_BVALID,
	output logic [1:0]       S_AXI_BRESP,
	input  wire logic        S_AXI_BREADY,
	input  wire logic        S_AXI_ARVALID,
	input  wire logic [7:0]  S_AXI_ARADDR,
	output logic             S_AXI_ARREADY,
	output logic             S_AXI_RVALID,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	input  wire logic        S_AXI_RREADY
);
	typedef enum {ST_IDLE, ST_TRIG, ST_DATA, ST_REPORT, ST_RETURN} state_t;

	state_t      state_ff;
	logic [15:0] err_ff;
	logic        pend_read_ff;
	logic        pend_valid_ff;
	logic        send_data_ff;
	logic        send_report_ff;
	logic [7:0]  trig_byte_ff;
	logic [1:0]  idx_ff;
	logic [15:0] rd_ff;
	logic        report_en_ff;
	tx_byte_t    tx_ff;
	logic        ret_ff;
	logic        exec_ff;
	logic [15:0] new_err;
	logic        abort_access;
	logic [7:0]  hdr0;
	logic [7:0]  hdr1;
	logic [7:0]  hdr2;
	logic [7:0]  ecc_byte;
	logic        tx_take;
	logic        nxt_valid;
	logic        nxt_trigger;
	logic        nxt_last;
	logic [7:0]  nxt_data;

	// header ECC over 24 header bits, same parity sets as the host
	function automatic logic [7:0] hdr_ecc(input logic [23:0] d);
		logic [5:0] p;
		p[0] = ^(d & 24'hF1_2BB7);
		p[1] = ^(d & 24'hF2_555B);
		p[2] = ^(d & 24'h74_A66D);
		p[3] = ^(d & 24'hB8_71F1);
		p[4] = ^(d & 24'hDF_820F);
		p[5] = ^(d & 24'hEF_FC00);
		return {2'b00, p};
	endfunction

	// flags from this transmission
	always_comb begin
		new_err = I_RX_SUM.other_err;
		new_err[ERR_ECC_SINGLE] = I_RX_SUM.ecc_single & ~I_RX_SUM.ecc_multi; // RL24
		new_err[ERR_ECC_MULTI]  = I_RX_SUM.ecc_multi; // RL24
	end
	assign abort_access = I_RX_SUM.ecc_multi | (|(I_RX_SUM.other_err & ERR_ABORT_MASK));

	// execute strobe for writes only when nothing forbids the access
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			exec_ff <= 1'b0;
		end else begin
			exec_ff <= I_RX_DONE & ~I_RX_SUM.is_read & ~abort_access; // RL8 RL18 RL20 RL21
		end
	end

	// sticky error register; new events win over the report clear
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			err_ff <= ERR_RESET;
		end else if (state_ff == ST_REPORT && tx_take && idx_ff == 2'd3) begin
			err_ff <= I_RX_DONE ? new_err : ERR_RESET; // RL7
		end else if (I_RX_DONE) begin
			err_ff <= err_ff | new_err; // RL26 RL8 RL9
		end
	end

	// remember the last transmission kind until a turnaround comes
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			pend_read_ff  <= 1'b0;
			pend_valid_ff <= 1'b0;
			rd_ff         <= 16'h0000;
		end else if (I_RX_DONE) begin
			pend_read_ff  <= I_RX_SUM.is_read & ~abort_access & ~(|(I_RX_SUM.other_err & ERR_NODATA_MASK));
			pend_valid_ff <= 1'b1;
			rd_ff         <= I_RD_DATA;
		end else if (state_ff == ST_IDLE && I_TURNAROUND) begin
			pend_valid_ff <= 1'b0;
		end
	end

	// reverse header bytes
	assign hdr0     = send_data_ff && state_ff == ST_DATA ? {VIRTUAL_CHANNEL_ID, DT_READ_SHORT} : {VIRTUAL_CHANNEL_ID, DT_ACK_ERR};
	assign hdr1     = state_ff == ST_DATA ? rd_ff[7:0] : err_ff[7:0];
	assign hdr2     = state_ff == ST_DATA ? rd_ff[15:8] : err_ff[15:8];
	assign ecc_byte = hdr_ecc({hdr2, hdr1, hdr0}); // RL3 RL10
	assign tx_take  = tx_ff.valid & I_TX_READY;

	// response selection and sequencing
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			state_ff       <= ST_IDLE;
			idx_ff         <= 2'd0;
			send_data_ff   <= 1'b0;
			send_report_ff <= 1'b0;
			trig_byte_ff   <= ACK_TRIGGER;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					idx_ff <= 2'd0;
					if (I_TURNAROUND) begin // RL14
						send_data_ff   <= pend_read_ff & pend_valid_ff; // RL16 RL17 RL19 RL22
						send_report_ff <= |err_ff; // RL17 RL18 RL19 RL20 RL21 RL22
						trig_byte_ff   <= ACK_TRIGGER; // RL25
						if (pend_read_ff && pend_valid_ff) begin
							state_ff <= ST_DATA;
						end else if (|err_ff) begin
							state_ff <= ST_REPORT;
						end else begin
							state_ff <= ST_TRIG; // RL6 RL15
						end
					end else if (I_TE_REQ) begin
						trig_byte_ff   <= TE_TRIGGER; // RL5
						send_report_ff <= 1'b0;
						state_ff       <= ST_TRIG;
					end
				end
				ST_TRIG: begin
					if (tx_take) begin
						state_ff <= ST_RETURN;
					end
				end
				ST_DATA: begin
					if (tx_take) begin
						idx_ff <= idx_ff + 2'd1;
						if (idx_ff == 2'd3) begin
							state_ff <= send_report_ff ? ST_REPORT : ST_RETURN;
						end
					end
				end
				ST_REPORT: begin
					if (tx_take) begin
						idx_ff <= idx_ff + 2'd1;
						if (idx_ff == 2'd3) begin
							state_ff <= ST_RETURN;
						end
					end
				end
				ST_RETURN: begin
					state_ff <= ST_IDLE; // RL4
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// next byte on the reverse stream, ordered per RL23
	always_comb begin
		nxt_valid   = 1'b0;
		nxt_trigger = 1'b0;
		nxt_last    = 1'b0;
		nxt_data    = 8'h00;
		case (state_ff)
			ST_TRIG: begin
				nxt_valid   = 1'b1;
				nxt_trigger = 1'b1;
				nxt_last    = 1'b1;
				nxt_data    = trig_byte_ff;
			end
			ST_DATA, ST_REPORT: begin
				nxt_valid = 1'b1;
				nxt_last  = (idx_ff == 2'd3) && !(state_ff == ST_DATA && send_report_ff);
				case (idx_ff)
					2'd0: nxt_data = hdr0; // RL23
					2'd1: nxt_data = hdr1;
					2'd2: nxt_data = hdr2;
					default: nxt_data = ecc_byte;
				endcase
			end
			default: begin
				nxt_valid = 1'b0;
			end
		endcase
		if (tx_take) begin
			nxt_valid = 1'b0;
		end
	end

	// registered byte interface, low power lane zero only
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			tx_ff <= '0;
			ret_ff <= 1'b0;
		end else begin
			tx_ff  <= {nxt_valid, nxt_trigger, nxt_last, nxt_data};
			ret_ff <= (state_ff == ST_RETURN); // RL4
		end
	end
	assign O_TX           = tx_ff;
	assign O_TX_LANE      = LANE_REVERSE; // RL1
	assign O_TX_LOW_POWER = 1'b1; // RL2
	assign O_BUS_RETURN   = ret_ff;
	assign O_EXEC         = exec_ff;

	// AXI4-Lite write channel
	logic aw_ff;
	logic w_ff;
	logic bvalid_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic        wstrb0_ff;
	// address and data may arrive in either order; the write lands once both are held
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			wstrb0_ff <= 1'b0;
			report_en_ff <= 1'b1;
		end else begin
			if (S_AXI_AWVALID && !aw_ff && !bvalid_ff) begin
				aw_ff <= 1'b1;
				awaddr_ff <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_ff && !bvalid_ff) begin
				w_ff <= 1'b1;
				wdata_ff <= S_AXI_WDATA;
				wstrb0_ff <= S_AXI_WSTRB[0];
			end
			if (aw_ff && w_ff) begin
				if (awaddr_ff == REG_CTRL && wstrb0_ff) begin
					report_en_ff <= wdata_ff[0];
				end
				aw_ff <= 1'b0;
				w_ff <= 1'b0;
				bvalid_ff <= 1'b1;
			end else if (bvalid_ff && S_AXI_BREADY) begin
				bvalid_ff <= 1'b0;
			end
		end
	end
	assign S_AXI_AWREADY = !aw_ff && !bvalid_ff;
	assign S_AXI_WREADY  = !w_ff && !bvalid_ff;
	assign S_AXI_BVALID  = bvalid_ff;
	assign S_AXI_BRESP   = (awaddr_ff == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;

	// AXI4-Lite read channel
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end else if (S_AXI_ARVALID && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= RESP_OKAY;
			case (S_AXI_ARADDR)
				REG_CTRL: rdata_ff <= {31'h0000_0000, report_en_ff};
				REG_ERR: rdata_ff <= {16'h0000, err_ff};
				REG_STATUS: rdata_ff <= {29'h0000_0000, pend_valid_ff, pend_read_ff, state_ff != ST_IDLE};
				REG_RDATA: rdata_ff <= {16'h0000, rd_ff};
				default: begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_ff && S_AXI_RREADY) begin
			rvalid_ff <= 1'b0;
		end
	end
	assign S_AXI_ARREADY = !rvalid_ff;
	assign S_AXI_RVALID  = rvalid_ff;
	assign S_AXI_RDATA   = rdata_ff;
	assign S_AXI_RRESP   = rresp_ff;

	// checks
	sequence report_start_s;
		state_ff == ST_REPORT && idx_ff == 2'd0;
	endsequence
	AST_ACK_CLEAN: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL6
		(state_ff == ST_IDLE && I_TURNAROUND && !(pend_read_ff && pend_valid_ff) && err_ff == 16'h0000)
		|=> state_ff == ST_TRIG && trig_byte_ff == ACK_TRIGGER) else $error("clean command not acked");
	AST_REPORT_CLEARS: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL7
		(state_ff == ST_REPORT && tx_take && idx_ff == 2'd3 && !I_RX_DONE) |=> err_ff == 16'h0000)
		else $error("report did not clear flags");
	AST_MULTI_NOEXEC: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL20
		(I_RX_DONE && I_RX_SUM.ecc_multi) |=> !exec_ff) else $error("multi-bit command executed");
	AST_STICKY: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL26
		(err_ff[ERR_SOT] && state_ff != ST_REPORT) |=> err_ff[ERR_SOT]) else $error("flag lost");
	AST_RETURN: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL4
		(state_ff == ST_RETURN) |=> ret_ff ##1 !ret_ff) else $error("no bus return pulse");
	AST_REPORT_HDR: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL23
		report_start_s |-> hdr0[5:0] == DT_ACK_ERR) else $error("bad report identifier");
endmodule : rev_resp
`default_nettype wire

// [sim/host_phy_model.sv]
`timescale 1ns/10ps
`default_nettype none
module host_phy_model (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// reverse byte stream from the device
	input  wire logic       i_slow,
	input  wire logic       i_valid,
	input  wire logic [1:0] i_lane,
	input  wire logic       i_low_power,
	output logic            o_ready
);
	logic [1:0] wait_ff;

	// one accept pulse per held byte; slow mode stalls two cycles first
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wait_ff <= 2'h0;
			o_ready <= 1'b0;
		end else begin
			o_ready <= i_valid && !o_ready && (!i_slow || wait_ff == 2'h2) && i_lane == 2'h0 && i_low_power;
			wait_ff <= (i_valid && !o_ready && wait_ff != 2'h2) ? wait_ff + 2'h1 : 2'h0;
		end
	end
endmodule // host_phy_model
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import rev_resp_pkg::*;
	localparam logic [1:0] VC = 2'h1;
	logic        clk, rst, rx_done, ta, te, slow, tx_ready, bus_ret, exec, lp;
	logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic [1:0]  lane, bresp, rresp;
	logic [7:0]  awa, ara;
	logic [15:0] rd;
	logic [31:0] wd, rdat;
	rx_summary_t sum;
	tx_byte_t    tx;
	int          miscompares, checks, exec_cnt;
	logic [7:0]  got[$];
	logic        trg[$];
	logic        lst[$];

	rev_resp #(.VIRTUAL_CHANNEL_ID(VC)) i_dut (
		.I_CLK(clk), .I_SYS_RST(rst), .I_RX_DONE(rx_done), .I_RX_SUM(sum), .I_TURNAROUND(ta),
		.I_TE_REQ(te), .I_RD_DATA(rd), .I_TX_READY(tx_ready), .O_TX(tx), .O_TX_LANE(lane),
		.O_TX_LOW_POWER(lp), .O_BUS_RETURN(bus_ret), .O_EXEC(exec),
		.S_AXI_AWVALID(awv), .S_AXI_AWADDR(awa), .S_AXI_AWREADY(awr), .S_AXI_WVALID(wv),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WREADY(wr), .S_AXI_BVALID(bv),
		.S_AXI_BRESP(bresp), .S_AXI_BREADY(br), .S_AXI_ARVALID(arv), .S_AXI_ARADDR(ara),
		.S_AXI_ARREADY(arr), .S_AXI_RVALID(rv), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
		.S_AXI_RREADY(rr)
	);
	host_phy_model i_phy (
		.i_clk(clk), .i_rst(rst), .i_slow(slow), .i_valid(tx.valid), .i_lane(lane),
		.i_low_power(lp), .o_ready(tx_ready)
	);

	// clock generator
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// counts execute pulses for the command paths
	always @(negedge clk) if (exec === 1'b1) exec_cnt++;

	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t byte %h expected %h", $time, g, e);
		end
	endtask

	task automatic cmp_bus(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t value %h expected %h", $time, g, e);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
			r = bresp;
		end while (bv !== 1'b1 && n < 100);
		br <= 1'b0;
		cmp_bus(32'(n < 100), 32'h0000_0001);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arv && arr) arv <= 1'b0;
			d = rdat;
			r = rresp;
		end while (rv !== 1'b1 && n < 100);
		rr <= 1'b0;
		cmp_bus(32'(n < 100), 32'h0000_0001);
	endtask

	// one forward transmission summary
	task automatic send(input logic r, input logic s, input logic m, input logic [15:0] o, input logic [15:0] d);
		@(posedge clk);
		rx_done <= 1'b1;
		sum <= '{r, s, m, o};
		rd <= d;
		@(posedge clk);
		rx_done <= 1'b0;
	endtask

	task automatic turn();
		@(posedge clk);
		ta <= 1'b1;
		@(posedge clk);
		ta <= 1'b0;
	endtask

	// gathers the reverse bytes up to the bus hand-back
	task automatic collect(input int n);
		bit ret;
		ret = 1'b0;
		got.delete();
		trg.delete();
		lst.delete();
		for (int i = 0; i < 120 && !ret; i++) begin
			@(negedge clk);
			if ((tx.valid & tx_ready) === 1'b1) begin
				got.push_back(tx.data);
				trg.push_back(tx.trigger);
				lst.push_back(tx.last);
				cmp_byte({5'h00, lp, lane}, {5'h00, 1'b1, LANE_REVERSE});
			end
			ret = ret | (bus_ret === 1'b1);
		end
		cmp_bus(got.size(), n);
		cmp_bus(32'(ret), 32'(n > 0));
		if (n > 0 && got.size() == n) begin
			cmp_bus(32'(lst[n - 1]), 32'h0000_0001);
		end
	endtask

	task automatic chk_rep(input int k, input logic [15:0] e);
		cmp_byte(got[k], {VC, DT_ACK_ERR});
		cmp_byte(got[k + 1], e[7:0]);
		cmp_byte(got[k + 2], e[15:8]);
	endtask

	task automatic s_ack();
		int e0;
		e0 = exec_cnt;
		send(1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000);
		turn();
		collect(1);
		cmp_byte(got[0], ACK_TRIGGER);
		cmp_bus(32'(trg[0]), 32'h0000_0001);
		cmp_bus(exec_cnt - e0, 32'h0000_0001);
	endtask

	task automatic s_read();
		@(posedge clk);
		slow <= 1'b1;
		send(1'b1, 1'b0, 1'b0, 16'h0000, 16'ha55a);
		turn();
		collect(4);
		cmp_byte(got[0], {VC, DT_READ_SHORT});
		cmp_byte(got[1], 8'h5a);
		cmp_byte(got[2], 8'ha5);
		@(posedge clk);
		slow <= 1'b0;
	endtask

	task automatic s_rd_single();
		send(1'b1, 1'b1, 1'b0, 16'h0000, 16'h1234);
		turn();
		collect(8);
		cmp_byte(got[1], 8'h34);
		chk_rep(4, 16'h0100);
	endtask

	task automatic s_sticky();
		int e0;
		logic [31:0] d;
		logic [1:0] r;
		e0 = exec_cnt;
		send(1'b0, 1'b0, 1'b0, 16'h0001, 16'h0000);
		collect(0);
		axi_rd(REG_ERR, d, r);
		cmp_bus(d, 32'h0000_0001);
		send(1'b1, 1'b0, 1'b0, 16'h1000, 16'h5555);
		turn();
		collect(4);
		chk_rep(0, 16'h1001);
		cmp_bus(exec_cnt - e0, 32'h0000_0000);
	endtask

	task automatic s_multi_wr();
		int e0;
		e0 = exec_cnt;
		send(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000);
		turn();
		collect(4);
		chk_rep(0, 16'h0200);
		cmp_bus(exec_cnt - e0, 32'h0000_0000);
	endtask

	task automatic s_errs();
		int b[8] = '{ERR_SOT, ERR_SOT_SYNC, ERR_VCID, ERR_PROTOCOL, ERR_CMD_UNREC, ERR_EOT_SYNC, ERR_LP_SYNC, ERR_CHECKSUM};
		logic [15:0] e;
		foreach (b[i]) begin
			e = 16'h0001 << b[i];
			send(1'b1, 1'b0, 1'b0, e, 16'h7777);
			turn();
			collect(4);
			chk_rep(0, e);
		end
	endtask

	task automatic s_te();
		@(posedge clk);
		te <= 1'b1;
		@(posedge clk);
		te <= 1'b0;
		collect(1);
		cmp_byte(got[0], TE_TRIGGER);
		cmp_bus(32'(trg[0]), 32'h0000_0001);
	endtask

	task automatic s_axi();
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(REG_CTRL, 32'h0000_0001, r);
		cmp_bus(r, RESP_OKAY);
		axi_rd(REG_CTRL, d, r);
		cmp_bus(d, 32'h0000_0001);
		axi_rd(8'h20, d, r);
		cmp_bus(r, RESP_SLVERR);
		axi_wr(8'h24, 32'h0000_0005, r);
		cmp_bus(r, RESP_SLVERR);
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		{rx_done, ta, te, slow, awv, wv, br, arv, rr} = '0;
		{awa, ara, wd, rd} = '0;
		sum = '0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		s_ack();
		s_read();
		s_rd_single();
		s_ack();
		s_sticky();
		s_multi_wr();
		s_errs();
		s_te();
		s_axi();
		complete_run();
	end

	// watchdog against a hang
	initial begin
		#(25 * 20000);
		miscompares++;
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
